// ---- rtl/tdt_pkg.sv ----
package tdt_pkg;
    // register addresses
    localparam logic [7:0] TDT_ADDR_TRANS_SRC = 8'h1E;
    localparam logic [7:0] TDT_ADDR_THS = 8'h1F;
    localparam logic [7:0] TDT_ADDR_COUNT = 8'h20;
    localparam logic [7:0] TDT_ADDR_TAP_CFG = 8'h21;
    localparam logic [7:0] TDT_ADDR_TAP_SRC = 8'h22;
    // reset values
    localparam logic [7:0] TDT_RST_THS = 8'h00;
    localparam logic [7:0] TDT_RST_COUNT = 8'h00;
    localparam logic [7:0] TDT_RST_TAP_CFG = 8'h00;
    // threshold register fields
    localparam int TDT_THS_MODE_BIT = 7;
    localparam int TDT_THS_MSB = 6;
    // tap configuration fields
    localparam int TDT_TAP_ABORT_BIT = 7;
    localparam int TDT_TAP_LATCH_BIT = 6;
    // source register fields
    localparam int TDT_TSRC_EA_BIT = 6;
    localparam int TDT_TAP_EA_BIT = 7;
    localparam int TDT_TAP_DPE_BIT = 3;
    // sample words are 12-bit at 8 g full scale; threshold lsb is 16 data lsb
    localparam int TDT_DATA_W = 12;
    localparam int TDT_THS_SHIFT = 4;
    localparam logic [7:0] TDT_CNT_MAX = 8'hFF;
endpackage : tdt_pkg

// ---- rtl/tdt_sync.sv ----
module tdt_sync
    import tdt_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic [WIDTH-1:0] ASYNC_IN,
    output logic [WIDTH-1:0] SYNC_OUT
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } tdt_sync_state_t;

    tdt_sync_state_t st_q;
    tdt_sync_state_t st_d;

    // two-stage shift; only the second stage is visible outside
    always_comb begin
        st_d = st_q;
        st_d.s1 = ASYNC_IN;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign SYNC_OUT = st_q.s2;
endmodule : tdt_sync

// ---- rtl/tdt_top.sv ----
// What this block does
// - compare filtered magnitude to threshold; flag event, interrupt only when enabled.
// - threshold is seven unsigned bits 6..0, always on an 8 g scale.
// - mode bit 7: failing sample decrements (0) or clears (1); passing increments.
// - event only once debounce count reaches the eight-bit programmed value; resets zero.
// - one debounce count lasts one sample step set by rate and oversampling.
// - six tap enables, single and double per axis; zero blocks the flag.
// - with tap latch bit 6 set, tap flags hold until the source read.
// - abort bit 7 set suspends double tap if tap starts and ends in latency.
// - abort bit clear keeps double-tap detection going through latency taps.
// - transient active flag set while latched freezes other transient status bits.
module tdt_top
    import tdt_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic SAMPLE_CLK,
    input wire logic [TDT_DATA_W-1:0] HPF_X,
    input wire logic [TDT_DATA_W-1:0] HPF_Y,
    input wire logic [TDT_DATA_W-1:0] HPF_Z,
    input wire logic [2:0] TAP_SINGLE,
    input wire logic [2:0] TAP_DOUBLE,
    input wire logic [2:0] TAP_POL,
    input wire logic TAP_LAT_ACTIVE,
    input wire logic TAP_PULSE_START,
    input wire logic TAP_PULSE_END,
    input wire logic [2:0] TRANS_AXIS_EN,
    input wire logic TRANS_LATCH_EN,
    input wire logic TRANS_INT_EN,
    output logic TRANS_EVENT,
    output logic TRANS_INT,
    output logic TAP_EVENT
);
    localparam int SW = 3 * TDT_DATA_W + 12;

    typedef struct packed {
        logic clk_prev;
        logic [7:0] ths;
        logic [7:0] count_cfg;
        logic [7:0] tap_cfg;
        logic [7:0] deb;
        logic [6:0] tsrc;
        logic [7:0] tsrc_tap;
        logic lat_start;
        logic dt_susp;
        logic [7:0] rdata;
        logic trans_ev;
    } tdt_state_t;

    tdt_state_t st_q;
    tdt_state_t st_d;

    logic sclk_s;
    logic [SW-1:0] smp_s;
    logic [TDT_DATA_W-1:0] ax [3];
    logic [2:0] tap_single_s;
    logic [2:0] tap_double_s;
    logic [2:0] tap_pol_s;
    logic lat_s;
    logic pstart_s;
    logic pend_s;

    // sample clock and everything made on it pass two flops first
    tdt_sync #(.WIDTH(1)) u_clk_sync (
        .CLOCK(CLOCK),
        .RST_B(RST_B),
        .ASYNC_IN(SAMPLE_CLK),
        .SYNC_OUT(sclk_s)
    );

    tdt_sync #(.WIDTH(SW)) u_smp_sync (
        .CLOCK(CLOCK),
        .RST_B(RST_B),
        .ASYNC_IN({HPF_X, HPF_Y, HPF_Z, TAP_SINGLE, TAP_DOUBLE, TAP_POL,
                   TAP_LAT_ACTIVE, TAP_PULSE_START, TAP_PULSE_END}),
        .SYNC_OUT(smp_s)
    );

    // unpack synchronised sample word
    assign ax[0] = smp_s[SW-1 -: TDT_DATA_W];
    assign ax[1] = smp_s[SW-1-TDT_DATA_W -: TDT_DATA_W];
    assign ax[2] = smp_s[SW-1-2*TDT_DATA_W -: TDT_DATA_W];
    assign tap_single_s = smp_s[11:9];
    assign tap_double_s = smp_s[8:6];
    assign tap_pol_s = smp_s[5:3];
    assign lat_s = smp_s[2];
    assign pstart_s = smp_s[1];
    assign pend_s = smp_s[0];

    always_comb begin
        logic step;
        logic [2:0] over;
        logic [2:0] pol;
        logic cond;
        logic [TDT_DATA_W-1:0] mag;
        logic [7:0] mag8;
        logic [7:0] cnt;
        logic tev;
        logic [2:0] tap_ax;
        logic dbl;
        logic tap_any;
        logic rd_tsrc;
        logic rd_tap;
        logic [7:0] tap_new;
        step = 1'b0;
        over = '0;
        pol = '0;
        cond = 1'b0;
        mag = '0;
        mag8 = '0;
        cnt = '0;
        tev = 1'b0;
        tap_ax = '0;
        dbl = 1'b0;
        tap_any = 1'b0;
        tap_new = '0;
        rd_tsrc = 1'b0;
        rd_tap = 1'b0;
        st_d = st_q;
        st_d.clk_prev = sclk_s;
        st_d.trans_ev = 1'b0;
        // one debounce step per rising edge of the sample clock
        step = sclk_s && !st_q.clk_prev;
        rd_tsrc = REG_RD && (REG_ADDR == TDT_ADDR_TRANS_SRC);
        rd_tap = REG_RD && (REG_ADDR == TDT_ADDR_TAP_SRC);

        // magnitude per axis on the fixed 8 g scale against the threshold
        for (int i = 0; i < 3; i++) begin
            mag = ax[i][TDT_DATA_W-1] ? (~ax[i] + 1'b1) : ax[i];
            // keep the top bit so a full-scale negative sample is not seen as zero
            mag8 = mag[TDT_DATA_W-1:TDT_THS_SHIFT];
            pol[i] = ax[i][TDT_DATA_W-1];
            over[i] = TRANS_AXIS_EN[i] && (mag8 > {1'b0, st_q.ths[TDT_THS_MSB:0]});
        end
        cond = |over;

        // debounce counter: saturating up, down or clear on a miss
        cnt = st_q.deb;
        if (cond) begin
            cnt = (st_q.deb == TDT_CNT_MAX) ? TDT_CNT_MAX : st_q.deb + 8'h01;
        end else if (st_q.ths[TDT_THS_MODE_BIT]) begin
            cnt = '0;
        end else if (st_q.deb != 8'h00) begin
            cnt = st_q.deb - 8'h01;
        end
        tev = step && cond && (cnt >= st_q.count_cfg);
        if (step) begin
            st_d.deb = cnt;
        end
        if (TRANS_AXIS_EN == 3'b000) begin
            st_d.deb = '0;
        end
        st_d.trans_ev = tev;

        // transient source: latched freeze while active, else per sample
        if (TRANS_LATCH_EN) begin
            if (rd_tsrc) begin
                st_d.tsrc = '0;
            end
            if (tev && (!st_q.tsrc[TDT_TSRC_EA_BIT] || rd_tsrc)) begin
                st_d.tsrc = {1'b1, over[2], pol[2], over[1], pol[1], over[0], pol[0]};
            end
        end else if (step) begin
            st_d.tsrc = tev ? {1'b1, over[2], pol[2], over[1], pol[1], over[0], pol[0]} : '0;
        end else if (rd_tsrc) begin
            st_d.tsrc = '0;
        end

        // double-tap abort: start and end both inside the latency window
        if (!lat_s || !st_q.tap_cfg[TDT_TAP_ABORT_BIT]) begin
            st_d.lat_start = 1'b0;
            st_d.dt_susp = 1'b0;
        end else if (step) begin
            if (pstart_s) begin
                st_d.lat_start = 1'b1;
            end
            if (pend_s && (st_q.lat_start || pstart_s)) begin
                st_d.dt_susp = 1'b1;
            end
        end

        // per-axis tap flags gated by the six enables
        for (int i = 0; i < 3; i++) begin
            tap_ax[i] = (tap_single_s[i] && st_q.tap_cfg[2*i]) ||
                        (tap_double_s[i] && st_q.tap_cfg[2*i+1] && !st_q.dt_susp);
            dbl = dbl || (tap_double_s[i] && st_q.tap_cfg[2*i+1] && !st_q.dt_susp);
        end
        tap_any = step && (|tap_ax);
        tap_new = {1'b1, tap_ax[2], tap_ax[1], tap_ax[0], dbl, tap_pol_s & tap_ax};
        if (st_q.tap_cfg[TDT_TAP_LATCH_BIT]) begin
            if (rd_tap) begin
                st_d.tsrc_tap = '0;
            end
            if (tap_any && (!st_q.tsrc_tap[TDT_TAP_EA_BIT] || rd_tap)) begin
                st_d.tsrc_tap = tap_new;
            end
        end else if (step) begin
            st_d.tsrc_tap = tap_any ? tap_new : '0;
        end else if (rd_tap) begin
            st_d.tsrc_tap = '0;
        end

        // register writes; rewriting the count clears the counter
        if (REG_WR) begin
            case (REG_ADDR)
                TDT_ADDR_THS: st_d.ths = REG_WDATA;
                TDT_ADDR_COUNT: begin
                    st_d.count_cfg = REG_WDATA;
                    st_d.deb = '0;
                end
                TDT_ADDR_TAP_CFG: st_d.tap_cfg = REG_WDATA;
                default: st_d.ths = st_q.ths;
            endcase
        end

        // register read data, valid the cycle after the read strobe
        if (REG_RD) begin
            case (REG_ADDR)
                TDT_ADDR_TRANS_SRC: st_d.rdata = {1'b0, st_q.tsrc};
                TDT_ADDR_THS: st_d.rdata = st_q.ths;
                TDT_ADDR_COUNT: st_d.rdata = st_q.count_cfg;
                TDT_ADDR_TAP_CFG: st_d.rdata = st_q.tap_cfg;
                TDT_ADDR_TAP_SRC: st_d.rdata = st_q.tsrc_tap;
                default: st_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            st_q <= '0;
            st_q.ths <= TDT_RST_THS;
            st_q.count_cfg <= TDT_RST_COUNT;
            st_q.tap_cfg <= TDT_RST_TAP_CFG;
        end else begin
            st_q <= st_d;
        end
    end

    assign REG_RDATA = st_q.rdata;
    assign TRANS_EVENT = st_q.trans_ev;
    // interrupt follows the active flag only when enabled
    assign TRANS_INT = st_q.tsrc[TDT_TSRC_EA_BIT] && TRANS_INT_EN;
    assign TAP_EVENT = st_q.tsrc_tap[TDT_TAP_EA_BIT];
endmodule : tdt_top

// ---- tb/tdt_src.sv ----
module tdt_src
    import tdt_pkg::*;
(
    input wire logic clock,
    output logic smp_clk,
    output logic [35:0] xyz,
    output logic [11:0] tap
);
    timeunit 1ns;
    timeprecision 100ps;
    // filter and tap front end, idle between steps
    initial begin
        smp_clk = 1'b0;
        xyz = '0;
        tap = '0;
    end
    // one sample: data settles one cycle before the rise, 200 ns period back to back
    task automatic step(input logic [35:0] d, input logic [11:0] t);
        @(negedge clock);
        xyz = d;
        tap = t;
        @(negedge clock);
        smp_clk = 1'b1;
        repeat (4) @(negedge clock);
        smp_clk = 1'b0;
        repeat (2) @(negedge clock);
    endtask : step
endmodule : tdt_src

// ---- tb/tdt_top_props.sv ----
module tdt_props
    import tdt_pkg::*;
(
    input wire logic CLOCK,
    input wire logic RST_B,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic SAMPLE_CLK,
    input wire logic [2:0] TRANS_AXIS_EN,
    input wire logic TRANS_LATCH_EN,
    input wire logic TRANS_INT_EN,
    input wire logic TRANS_EVENT,
    input wire logic TRANS_INT,
    input wire logic TAP_EVENT
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);
    logic [7:0] cfg_q;
    // shadow of the tap configuration register
    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) cfg_q <= 8'h00;
        else if (REG_WR && REG_ADDR == TDT_ADDR_TAP_CFG) cfg_q <= REG_WDATA;
    end
    // source reads far from any sample step
    sequence tap_rd_s;
        REG_RD && REG_ADDR == TDT_ADDR_TAP_SRC && !$past(SAMPLE_CLK, 1)
            && !$past(SAMPLE_CLK, 2) && !$past(SAMPLE_CLK, 3);
    endsequence
    sequence tap_kept_s;
        TAP_EVENT && cfg_q[6] && !(REG_RD && REG_ADDR == TDT_ADDR_TAP_SRC)
            && !$past(REG_RD && REG_ADDR == TDT_ADDR_TAP_SRC);
    endsequence
    sequence trans_kept_s;
        TRANS_INT && TRANS_LATCH_EN && !(REG_RD && REG_ADDR == TDT_ADDR_TRANS_SRC)
            && !$past(REG_RD && REG_ADDR == TDT_ADDR_TRANS_SRC);
    endsequence
    int_gate_a: assert property (TRANS_INT |-> TRANS_INT_EN)
        else $error("transient interrupt while disabled");
    event_pulse_a: assert property (TRANS_EVENT |=> !TRANS_EVENT)
        else $error("transient event longer than one cycle");
    event_step_a: assert property (TRANS_EVENT |-> $past(SAMPLE_CLK, 2))
        else $error("transient event without a sample step");
    event_axis_a: assert property (TRANS_EVENT |-> |$past(TRANS_AXIS_EN))
        else $error("transient event with all axes off");
    cfg_read_a: assert property (REG_RD && !REG_WR && REG_ADDR == TDT_ADDR_TAP_CFG
        |=> REG_RDATA == cfg_q)
        else $error("tap configuration read back wrong");
    tap_gate_a: assert property ($rose(TAP_EVENT) |-> |cfg_q[5:0])
        else $error("tap event with all enables off");
    tap_clear_a: assert property (tap_rd_s |-> ##2 !TAP_EVENT)
        else $error("tap flag not cleared by read");
    tap_hold_a: assert property (tap_kept_s |=> TAP_EVENT)
        else $error("latched tap flag dropped");
    trans_hold_a: assert property (trans_kept_s |=> TRANS_INT || !TRANS_INT_EN)
        else $error("latched transient flag dropped");
endmodule : tdt_props

// ---- tb/tdt_top_tb_top.sv ----
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %h got %h", n, e, s); end end
module tdt_top_tb_top
    import tdt_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic latch_en = 1'b0;
    logic [2:0] axis_en = 3'b001;
    logic int_en = 1'b1;
    logic [7:0] rdata, v, e;
    logic smp_clk, trans_ev, trans_int, tap_ev;
    logic [35:0] xyz;
    logic [11:0] tap, t;
    logic [11:0] pat [5] = '{12'h110, 12'hEF0, 12'h100, 12'h110, 12'h110};
    int mismatches = 0;
    int samples_checked = 0;
    int ev_cnt = 0;
    tdt_src SRC (.clock(clock), .smp_clk(smp_clk), .xyz(xyz), .tap(tap));
    tdt_top DUT (.CLOCK(clock), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .SAMPLE_CLK(smp_clk),
        .HPF_X(xyz[35:24]), .HPF_Y(xyz[23:12]), .HPF_Z(xyz[11:0]), .TAP_SINGLE(tap[11:9]),
        .TAP_DOUBLE(tap[8:6]), .TAP_POL(tap[5:3]), .TAP_LAT_ACTIVE(tap[2]),
        .TAP_PULSE_START(tap[1]), .TAP_PULSE_END(tap[0]), .TRANS_AXIS_EN(axis_en),
        .TRANS_LATCH_EN(latch_en), .TRANS_INT_EN(int_en), .TRANS_EVENT(trans_ev),
        .TRANS_INT(trans_int), .TAP_EVENT(tap_ev));
    // clock and transient event counter
    initial begin
        forever #12.5 clock = ~clock;
    end
    always @(negedge clock) if (trans_ev === 1'b1) ev_cnt++;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        addr = a;
        wdata = d;
        reg_wr = 1'b1;
        @(negedge clock);
        reg_wr = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(negedge clock);
        addr = a;
        reg_rd = 1'b1;
        @(negedge clock);
        reg_rd = 1'b0;
        v = rdata;
    endtask : rd
    // y and z carry large values but stay disabled
    task automatic smp(input logic [11:0] x, input logic [11:0] tp);
        SRC.step({x, 12'h7F0, 12'h7F0}, tp);
    endtask : smp
    task automatic ev(input int n);
        `CHK("events", n, ev_cnt)
        ev_cnt = 0;
    endtask : ev
    task automatic finish_test;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : finish_test
    // watchdog well beyond the expected run
    initial begin
        #100000;
        mismatches++;
        finish_test();
    end
    // main sequence
    initial begin
        repeat (5) @(negedge clock);
        rst_b = 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(TDT_ADDR_THS + 8'(i));
            `CHK("reset", 8'h00, v)
            wr(TDT_ADDR_THS + 8'(i), 8'hA5);
            rd(TDT_ADDR_THS + 8'(i));
            `CHK("rw", (i < 3) ? 8'hA5 : 8'h00, v)
        end
        for (int m = 0; m < 2; m++) begin
            wr(TDT_ADDR_THS, m ? 8'h90 : 8'h10);
            wr(TDT_ADDR_COUNT, 8'h03);
            foreach (pat[i]) smp(pat[i], 12'h000);
            ev(1 - m);
        end
        smp(12'h110, 12'h000);
        ev(1);
        `CHK("int", 1'b1, trans_int)
        int_en = 1'b0;
        @(negedge clock);
        `CHK("int_off", 1'b0, trans_int)
        int_en = 1'b1;
        rd(TDT_ADDR_TRANS_SRC);
        `CHK("trans_src", 8'h42, v)
        `CHK("int_clr", 1'b0, trans_int)
        latch_en = 1'b1;
        wr(TDT_ADDR_COUNT, 8'h00);
        smp(12'h110, 12'h000);
        smp(12'hEF0, 12'h000);
        smp(12'h000, 12'h000);
        ev(2);
        rd(TDT_ADDR_TRANS_SRC);
        `CHK("trans_latch", 8'h42, v)
        rd(TDT_ADDR_TRANS_SRC);
        `CHK("trans_clr", 8'h00, v)
        latch_en = 1'b0;
        // disabling every axis drops a half-built debounce count
        wr(TDT_ADDR_THS, 8'h10);
        wr(TDT_ADDR_COUNT, 8'h03);
        smp(12'h110, 12'h000);
        smp(12'h110, 12'h000);
        axis_en = 3'b000;
        @(negedge clock);
        axis_en = 3'b001;
        smp(12'h110, 12'h000);
        smp(12'h110, 12'h000);
        ev(0);
        smp(12'h110, 12'h000);
        ev(1);
        for (int i = 0; i < 6; i++) begin
            wr(TDT_ADDR_TAP_CFG, 8'(1 << i));
            t = ((i % 2) ? (12'h040 << (i / 2)) : (12'h200 << (i / 2))) | 12'h038;
            smp(12'h000, ((i % 2) ? (12'h200 << (i / 2)) : (12'h040 << (i / 2))) | 12'h038);
            `CHK("tap_blk", 1'b0, tap_ev)
            smp(12'h000, t);
            rd(TDT_ADDR_TAP_SRC);
            e = 8'h80 | (8'h11 << (i / 2)) | 8'((i % 2) * 8);
            `CHK("tap_src", e, v)
        end
        wr(TDT_ADDR_TAP_CFG, 8'h41);
        smp(12'h000, 12'h200);
        smp(12'h000, 12'h000);
        `CHK("tap_hold", 1'b1, tap_ev)
        rd(TDT_ADDR_TAP_SRC);
        `CHK("tap_latch", 8'h90, v)
        repeat (2) @(negedge clock);
        `CHK("tap_clr", 1'b0, tap_ev)
        for (int a = 0; a < 2; a++) begin
            wr(TDT_ADDR_TAP_CFG, a ? 8'h82 : 8'h02);
            smp(12'h000, 12'h007);
            smp(12'h000, 12'h047);
            `CHK("dbl_tap", a ? 1'b0 : 1'b1, tap_ev)
        end
        finish_test();
    end
endmodule : tdt_top_tb_top
bind tdt_top tdt_props u_props (.CLOCK, .RST_B, .REG_ADDR, .REG_WDATA, .REG_WR,
    .REG_RD, .REG_RDATA, .SAMPLE_CLK, .TRANS_AXIS_EN, .TRANS_LATCH_EN, .TRANS_INT_EN,
    .TRANS_EVENT, .TRANS_INT, .TAP_EVENT);
